// file: design/routing_pkg.sv
// Package with switch layouts, reset values, timing constants and carrier types.
package routing_pkg;

  // ---------------------------------------------------------------------------
  // Switch group reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] BLOCK_SW_RESET = 8'h00;
  localparam logic [7:0] MATRIX1_RESET  = 8'hab;
  localparam logic [7:0] MATRIX2_RESET  = 8'ha5;
  localparam logic [7:0] MATRIX3_RESET  = 8'h00;
  localparam logic [7:0] FSEL_A_RESET   = 8'h00;
  localparam logic [7:0] FSEL_B_RESET   = 8'h00;
  localparam logic [7:0] SYS_SW_RESET   = 8'h07;

  // ---------------------------------------------------------------------------
  // Field positions (bit index = switch number minus one)
  // ---------------------------------------------------------------------------
  localparam int SYS_START_A_TO_C = 0;
  localparam int SYS_TRIP_TO_A    = 1;
  localparam int SYS_EARTH_LOW_TR = 2;
  localparam int SYS_ALL_TO_A     = 6;
  localparam int SYS_ALL_TO_B     = 7;
  localparam int FSA_TRIP_B_TO_A  = 3;
  localparam int FSB_HIGH_AR_A    = 6;
  localparam int FSB_EARTH_AR_C   = 7;
  localparam int BLK_BANK_SEL     = 4;
  localparam int BLK_LATCH_OC     = 5;
  localparam int BLK_LATCH_EF     = 6;
  localparam int BLK_REMOTE_RST   = 7;

  // Stage indices.
  localparam int ST_LOW_PHASE  = 0;
  localparam int ST_HIGH_PHASE = 1;
  localparam int ST_EARTH_LOW  = 2;
  localparam int ST_EARTH_HIGH = 3;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ         = 100;
  localparam int ALARM_DELAY_MS  = 40;
  localparam int ALARM_DELAY_CYC = ALARM_DELAY_MS * 1000 * CLK_MHZ;
  localparam int BACKUP_DELAY_MS = 100;
  localparam int BACKUP_DELAY_CYC = BACKUP_DELAY_MS * 1000 * CLK_MHZ;

  typedef struct packed {
    logic [3:0] start;
    logic [3:0] operate;
  } stage_sig_s;

  typedef struct packed {
    logic trip_line_a;
    logic trip_line_b;
    logic start_line_a;
    logic start_line_b;
    logic reclose_start_a;
    logic reclose_start_b;
    logic reclose_start_c;
  } lines_s;

endpackage

// file: design/delay_timer.sv
// Delay qualifier: output rises after its input has stood high for a set count.
`timescale 1ns/1ps
`default_nettype none
module delay_timer #(
  parameter int CNT_W = 32
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             enable,
  input  wire logic             level_in,
  input  wire logic [CNT_W-1:0] delay_cycles,
  output logic                  level_out
);

  logic [CNT_W-1:0] count_q;

  // The count restarts whenever the input drops, so only a persistent
  // condition reaches the output.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q   <= '0;
      level_out <= 1'b0;
    end else if (!enable || !level_in) begin
      count_q   <= '0;
      level_out <= 1'b0;
    end else if (count_q + 1'b1 >= delay_cycles) begin
      level_out <= 1'b1;
    end else begin
      count_q <= count_q + 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: design/protection_signal_routing_matrix.sv
// Routing and conditioning matrix between four protection stages and outputs.
// Operation
// - Earth low trip with routing switch clear drives alarm b and inhibits reclose.
// - Trip-to-first-alarm switch copies every trip source onto alarm a.
// - Trip-to-second-alarm switch copies every trip source onto alarm b.
// - Alarm a and b may be delayed 40 ms when signalling operation.
// - Reclose in progress holds alarm a and b inactive.
// - function_select_a bit 4 delays trip_line_b into trip_line_a if fault persists.
// - function_select_b bit 7 routes high phase start to reclose_start_a.
// - function_select_b bit 8 routes both earth starts to reclose_start_c.
// - Blocking switches 1 to 4 let block_input block each stage.
// - Blocking switch 5 lets block_input select the second settings bank.
// - Blocking switches 6 and 7 latch trip_line_b for overcurrent and earth.
// - Blocking switch 8 lets block_input reset a latched output.
// - Odd bits of matrix one route starts to start_line_a and reclose_start_b.
// - Even bits of matrix one route operates to trip_line_b.
// - Odd bits of matrix two route operates to start_line_b.
// - Even bits of matrix two route operates to reclose_start_a.
// - Matrix three bits route start then operate of each stage to trip_line_a.
// - Switch group value is its bit weight sum; matrix defaults 171 and 165.
// - Earth low routing switch set links that stage's trip to main trip.
// - Main trip follows both trip lines; alarm a via second system switch.
// - Alarm c follows start_line_b, and start_line_a via first system switch.
`timescale 1ns/1ps
`default_nettype none
module protection_signal_routing_matrix #(
  parameter int ALARM_DELAY_CYC  = routing_pkg::ALARM_DELAY_CYC,
  parameter int BACKUP_DELAY_CYC = routing_pkg::BACKUP_DELAY_CYC
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire routing_pkg::stage_sig_s stage_in,
  input  wire logic                   block_input,
  input  wire logic                   reclose_in_progress,
  input  wire logic                   alarm_delay_en,
  input  wire logic                   sw_we,
  input  wire logic [2:0]             sw_sel,
  input  wire logic [7:0]             sw_wdata,
  output logic [7:0]                  blocking_control_switches,
  output logic [7:0]                  output_matrix_one,
  output logic [7:0]                  output_matrix_two,
  output logic [7:0]                  output_matrix_three,
  output logic [7:0]                  function_select_a,
  output logic [7:0]                  function_select_b,
  output logic [7:0]                  system_output_switches,
  output routing_pkg::lines_s         lines_q,
  output logic [3:0]                  stage_block_q,
  output logic                        second_bank_q,
  output logic                        main_trip_q,
  output logic                        alarm_out_a,
  output logic                        alarm_out_b,
  output logic                        alarm_out_c,
  output logic                        reclose_inhibit_q,
  output logic                        trip_b_latched_q
);

  // ---------------------------------------------------------------------------
  // Switch groups
  // ---------------------------------------------------------------------------
  localparam logic [2:0] SEL_BLOCK = 3'h0;
  localparam logic [2:0] SEL_M1    = 3'h1;
  localparam logic [2:0] SEL_M2    = 3'h2;
  localparam logic [2:0] SEL_M3    = 3'h3;
  localparam logic [2:0] SEL_FSA   = 3'h4;
  localparam logic [2:0] SEL_FSB   = 3'h5;
  localparam logic [2:0] SEL_SYS   = 3'h6;

  // Each group is held as its bit pattern, whose value is the weight sum.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      blocking_control_switches <= routing_pkg::BLOCK_SW_RESET;
      output_matrix_one         <= routing_pkg::MATRIX1_RESET;
      output_matrix_two         <= routing_pkg::MATRIX2_RESET;
      output_matrix_three       <= routing_pkg::MATRIX3_RESET;
      function_select_a         <= routing_pkg::FSEL_A_RESET;
      function_select_b         <= routing_pkg::FSEL_B_RESET;
      system_output_switches    <= routing_pkg::SYS_SW_RESET;
    end else if (sw_we) begin
      unique case (sw_sel)
        SEL_BLOCK: blocking_control_switches <= sw_wdata;
        SEL_M1:    output_matrix_one         <= sw_wdata;
        SEL_M2:    output_matrix_two         <= sw_wdata;
        SEL_M3:    output_matrix_three       <= sw_wdata;
        SEL_FSA:   function_select_a         <= sw_wdata;
        SEL_FSB:   function_select_b         <= sw_wdata;
        SEL_SYS:   system_output_switches    <= sw_wdata;
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Stage blocking and bank selection
  // ---------------------------------------------------------------------------
  logic [3:0] blk;
  logic [3:0] st;
  logic [3:0] op;
  logic       remote_rst;

  assign blk = {4{block_input}} & blocking_control_switches[3:0];
  assign st  = stage_in.start & ~blk;
  assign op  = stage_in.operate & ~blk;
  assign remote_rst = block_input
                    & blocking_control_switches[routing_pkg::BLK_REMOTE_RST];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_block_q <= 4'h0;
      second_bank_q <= 1'b0;
    end else begin
      stage_block_q <= blk;
      second_bank_q <= block_input
                     & blocking_control_switches[routing_pkg::BLK_BANK_SEL];
    end
  end

  // ---------------------------------------------------------------------------
  // Output matrices
  // ---------------------------------------------------------------------------
  logic [3:0] m1_start;
  logic [3:0] m1_op;
  logic [3:0] m2_ss;
  logic [3:0] m2_ar;
  logic [3:0] m3_st;
  logic [3:0] m3_op;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_stage
      assign m1_start[g] = st[g] & output_matrix_one[2*g];
      assign m1_op[g]    = op[g] & output_matrix_one[2*g+1];
      assign m2_ss[g]    = op[g] & output_matrix_two[2*g];
      assign m2_ar[g]    = op[g] & output_matrix_two[2*g+1];
      assign m3_st[g]    = st[g] & output_matrix_three[2*g];
      assign m3_op[g]    = op[g] & output_matrix_three[2*g+1];
    end
  endgenerate

  logic trip_b_oc_src;
  logic trip_b_ef_src;
  logic trip_b_raw;
  logic trip_b;
  logic latch_oc_q;
  logic latch_ef_q;
  logic backup_trip;
  logic trip_a;

  assign trip_b_oc_src = m1_op[routing_pkg::ST_LOW_PHASE] | m1_op[routing_pkg::ST_HIGH_PHASE];
  assign trip_b_ef_src = m1_op[routing_pkg::ST_EARTH_LOW] | m1_op[routing_pkg::ST_EARTH_HIGH];
  assign trip_b_raw    = trip_b_oc_src | trip_b_ef_src;

  // Latches hold trip_line_b after the source clears; the remote reset is a
  // level, so a standing fault re-latches as soon as the reset goes away.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_oc_q <= 1'b0;
      latch_ef_q <= 1'b0;
    end else if (remote_rst) begin
      latch_oc_q <= 1'b0;
      latch_ef_q <= 1'b0;
    end else begin
      if (trip_b_oc_src && blocking_control_switches[routing_pkg::BLK_LATCH_OC]) begin
        latch_oc_q <= 1'b1;
      end
      if (trip_b_ef_src && blocking_control_switches[routing_pkg::BLK_LATCH_EF]) begin
        latch_ef_q <= 1'b1;
      end
    end
  end

  assign trip_b = trip_b_raw | latch_oc_q | latch_ef_q;

  delay_timer #(
    .CNT_W (32)
  ) u_backup (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .enable       (function_select_a[routing_pkg::FSA_TRIP_B_TO_A]),
    .level_in     (trip_b_raw),
    .delay_cycles (32'(BACKUP_DELAY_CYC)),
    .level_out    (backup_trip)
  );

  assign trip_a = (|m3_st) | (|m3_op) | backup_trip;

  logic start_a;
  logic start_b;
  logic ar_a;
  logic ar_b;
  logic ar_c;

  assign start_a = |m1_start;
  assign ar_b    = |m1_start;
  assign start_b = |m2_ss;
  assign ar_a    = (|m2_ar)
                 | (st[routing_pkg::ST_HIGH_PHASE]
                    & function_select_b[routing_pkg::FSB_HIGH_AR_A]);
  assign ar_c    = (st[routing_pkg::ST_EARTH_LOW] | st[routing_pkg::ST_EARTH_HIGH])
                 & function_select_b[routing_pkg::FSB_EARTH_AR_C];

  // ---------------------------------------------------------------------------
  // System outputs
  // ---------------------------------------------------------------------------
  logic earth_low_to_trip;
  logic earth_low_signal;
  logic trip_all;
  logic alarm_a_src;
  logic alarm_b_src;
  logic alarm_a_del;
  logic alarm_b_del;

  assign earth_low_to_trip = system_output_switches[routing_pkg::SYS_EARTH_LOW_TR];
  assign earth_low_signal  = op[routing_pkg::ST_EARTH_LOW] & ~earth_low_to_trip;
  assign trip_all = trip_a | trip_b
                  | (op[routing_pkg::ST_EARTH_LOW] & earth_low_to_trip);

  assign alarm_a_src = ((trip_a | trip_b) & system_output_switches[routing_pkg::SYS_TRIP_TO_A])
                     | (trip_all & system_output_switches[routing_pkg::SYS_ALL_TO_A]);
  assign alarm_b_src = earth_low_signal
                     | (trip_all & system_output_switches[routing_pkg::SYS_ALL_TO_B]);

  // Delaying lets a reclose sequence start first, so a successful reclose
  // never raises a needless alarm.
  delay_timer #(
    .CNT_W (32)
  ) u_alarm_a_dly (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .enable       (1'b1),
    .level_in     (alarm_a_src),
    .delay_cycles (32'(ALARM_DELAY_CYC)),
    .level_out    (alarm_a_del)
  );

  delay_timer #(
    .CNT_W (32)
  ) u_alarm_b_dly (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .enable       (1'b1),
    .level_in     (alarm_b_src),
    .delay_cycles (32'(ALARM_DELAY_CYC)),
    .level_out    (alarm_b_del)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_out_a <= 1'b0;
      alarm_out_b <= 1'b0;
    end else if (reclose_in_progress) begin
      alarm_out_a <= 1'b0;
      alarm_out_b <= 1'b0;
    end else begin
      alarm_out_a <= alarm_delay_en ? alarm_a_del : alarm_a_src;
      alarm_out_b <= alarm_delay_en ? alarm_b_del : alarm_b_src;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lines_q           <= '0;
      main_trip_q       <= 1'b0;
      alarm_out_c       <= 1'b0;
      reclose_inhibit_q <= 1'b0;
      trip_b_latched_q  <= 1'b0;
    end else begin
      lines_q.trip_line_a     <= trip_a;
      lines_q.trip_line_b     <= trip_b;
      lines_q.start_line_a    <= start_a;
      lines_q.start_line_b    <= start_b;
      lines_q.reclose_start_a <= ar_a;
      lines_q.reclose_start_b <= ar_b;
      lines_q.reclose_start_c <= ar_c;
      main_trip_q       <= trip_all;
      alarm_out_c       <= start_b
                         | (start_a & system_output_switches[routing_pkg::SYS_START_A_TO_C]);
      reclose_inhibit_q <= earth_low_signal;
      trip_b_latched_q  <= latch_oc_q | latch_ef_q;
    end
  end

endmodule
`default_nettype wire

// file: verification/routing_matrix_sva.sv
// Concurrent checks on the routing matrix ports.
`timescale 1ns/1ps
`default_nettype none
module routing_matrix_sva (
  input wire logic                    core_clk,
  input wire logic                    rst_n,
  input wire routing_pkg::stage_sig_s stage_in,
  input wire logic                    block_input,
  input wire logic                    reclose_in_progress,
  input wire logic                    sw_we,
  input wire logic [2:0]              sw_sel,
  input wire logic [7:0]              sw_wdata,
  input wire logic [7:0]              blocking_control_switches,
  input wire logic [7:0]              output_matrix_one,
  input wire logic [7:0]              output_matrix_two,
  input wire logic [7:0]              function_select_b,
  input wire routing_pkg::lines_s     lines_q,
  input wire logic [3:0]              stage_block_q,
  input wire logic                    second_bank_q,
  input wire logic                    main_trip_q,
  input wire logic                    alarm_out_a,
  input wire logic                    alarm_out_b,
  input wire logic                    alarm_out_c
);
  logic [3:0] bk;
  logic [3:0] st;
  logic [3:0] op;
  assign bk = block_input ? blocking_control_switches[3:0] : 4'h0;
  assign st = stage_in.start & ~bk;
  assign op = stage_in.operate & ~bk;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Odd-numbered switches sit on even bit positions and carry the start routes.
  function automatic logic [3:0] ev(input logic [7:0] x);
    return {x[6], x[4], x[2], x[0]};
  endfunction
  function automatic logic [3:0] od(input logic [7:0] x);
    return {x[7], x[5], x[3], x[1]};
  endfunction
  a_start_a_route: assert property (
    lines_q.start_line_a == $past(|(st & ev(output_matrix_one))))
    else $error("start_line_a route wrong");
  a_start_b_route: assert property (
    lines_q.start_line_b == $past(|(op & ev(output_matrix_two))))
    else $error("start_line_b route wrong");
  a_reclose_a_route: assert property (
    lines_q.reclose_start_a == $past(|(op & od(output_matrix_two)) | (function_select_b[6] & st[1])))
    else $error("reclose_start_a route wrong");
  a_reclose_c_route: assert property (
    lines_q.reclose_start_c == $past(function_select_b[7] & (|st[3:2])))
    else $error("reclose_start_c route wrong");
  a_trip_b_route: assert property (
    $past(|(op & od(output_matrix_one))) |-> lines_q.trip_line_b)
    else $error("trip_line_b not raised");
  a_main_trip_follow: assert property (
    (lines_q.trip_line_a || lines_q.trip_line_b) |-> main_trip_q)
    else $error("main trip missing");
  a_alarm_c_follow: assert property (
    lines_q.start_line_b |-> alarm_out_c)
    else $error("alarm_out_c missing");
  a_reclose_alarm_hold: assert property (
    $past(reclose_in_progress) |-> !alarm_out_a && !alarm_out_b)
    else $error("alarm active during reclose");
  a_stage_block_bank: assert property (
    {stage_block_q, second_bank_q} == $past({bk, block_input & blocking_control_switches[4]}))
    else $error("block or bank select wrong");
  a_matrix_write: assert property (
    $past(sw_we && sw_sel == 3'h1) |-> output_matrix_one == $past(sw_wdata))
    else $error("matrix one write lost");
endmodule
bind protection_signal_routing_matrix routing_matrix_sva u_sva (
  .core_clk, .rst_n, .stage_in, .block_input, .reclose_in_progress, .sw_we, .sw_sel,
  .sw_wdata, .blocking_control_switches, .output_matrix_one, .output_matrix_two,
  .function_select_b, .lines_q, .stage_block_q, .second_bank_q, .main_trip_q,
  .alarm_out_a, .alarm_out_b, .alarm_out_c
);
`default_nettype wire

// file: verification/stage_model.sv
// Behavioural model of the protection stages and the reclose unit.
`timescale 1ns/1ps
`default_nettype none
module stage_model (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic [3:0]              cmd_start,
  input  wire logic [3:0]              cmd_op,
  input  wire logic                    cmd_block,
  input  wire logic                    cmd_busy,
  output var  routing_pkg::stage_sig_s stage_out,
  output logic                         block_out,
  output logic                         busy_out
);
  // A stage never operates without having started, so operate also raises start.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_out <= 8'h00;
    end else begin
      stage_out.start   <= cmd_start | cmd_op;
      stage_out.operate <= cmd_op;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      block_out <= 1'b0;
      busy_out  <= 1'b0;
    end else begin
      block_out <= cmd_block;
      busy_out  <= cmd_busy;
    end
  end
endmodule
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the protection routing matrix.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int AD = 20;
  localparam int BK = 20;
  typedef struct {int id; logic [7:0] v; int due;} note_s;
  logic                    core_clk, rst_n, cmd_block, cmd_busy, alarm_delay_en, sw_we;
  logic [3:0]              cmd_start, cmd_op, stage_block_q;
  logic [2:0]              sw_sel;
  logic [7:0]              sw_wdata;
  logic [7:0]              rd [7];
  logic [7:0]              sh [7];
  routing_pkg::stage_sig_s stage_in;
  routing_pkg::lines_s     lines_q;
  logic                    block_input, reclose_in_progress, second_bank_q, main_trip_q;
  logic                    alarm_out_a, alarm_out_b, alarm_out_c, reclose_inhibit_q, trip_b_latched_q;
  int                      cyc, err_count, samples_checked;
  note_s                   q [$];
  string nm [10] = '{"blocking", "m1", "m2", "m3", "fsel_a", "fsel_b", "system", "lines",
                     "status", "block_bank"};
  stage_model u_stage (.core_clk(core_clk), .rst_n(rst_n), .cmd_start(cmd_start),
    .cmd_op(cmd_op), .cmd_block(cmd_block), .cmd_busy(cmd_busy), .stage_out(stage_in),
    .block_out(block_input), .busy_out(reclose_in_progress));
  protection_signal_routing_matrix #(.ALARM_DELAY_CYC(AD), .BACKUP_DELAY_CYC(BK)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .stage_in(stage_in), .block_input(block_input),
    .reclose_in_progress(reclose_in_progress), .alarm_delay_en(alarm_delay_en),
    .sw_we(sw_we), .sw_sel(sw_sel), .sw_wdata(sw_wdata),
    .blocking_control_switches(rd[0]), .output_matrix_one(rd[1]), .output_matrix_two(rd[2]),
    .output_matrix_three(rd[3]), .function_select_a(rd[4]), .function_select_b(rd[5]),
    .system_output_switches(rd[6]), .lines_q(lines_q), .stage_block_q(stage_block_q),
    .second_bank_q(second_bank_q), .main_trip_q(main_trip_q), .alarm_out_a(alarm_out_a),
    .alarm_out_b(alarm_out_b), .alarm_out_c(alarm_out_c),
    .reclose_inhibit_q(reclose_inhibit_q), .trip_b_latched_q(trip_b_latched_q));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;
  function automatic logic [3:0] ev(input logic [7:0] x);
    return {x[6], x[4], x[2], x[0]};
  endfunction
  function automatic logic [3:0] od(input logic [7:0] x);
    return {x[7], x[5], x[3], x[1]};
  endfunction
  // Returns {alarm a, alarm b, alarm c, main trip, inhibit, latched, seven lines}.
  function automatic logic [12:0] expv(input logic [7:0] s, input logic b, input logic rp);
    logic [3:0] k;
    logic [3:0] t;
    logic [3:0] o;
    logic [5:0] a;
    logic [6:0] l;
    k = b ? sh[0][3:0] : 4'h0;
    t = s[7:4] & ~k;
    o = s[3:0] & ~k;
    l[6] = |({o[3], t[3], o[2], t[2], o[1], t[1], o[0], t[0]} & sh[3]);
    l[5] = |(o & od(sh[1]));
    l[4] = |(t & ev(sh[1]));
    l[3] = |(o & ev(sh[2]));
    l[2] = |(o & od(sh[2])) | (sh[5][6] & t[1]);
    l[1] = l[4];
    l[0] = sh[5][7] & (|t[3:2]);
    a[2] = l[6] | l[5] | (sh[6][2] & o[2]);
    a[5] = ~rp & ((sh[6][1] & (l[6] | l[5])) | (sh[6][6] & a[2]));
    a[4] = ~rp & ((~sh[6][2] & o[2]) | (sh[6][7] & a[2]));
    a[3] = l[3] | (l[4] & sh[6][0]);
    a[1] = ~sh[6][2] & o[2];
    a[0] = 1'b0;
    return {a, l};
  endfunction
  function automatic logic [7:0] obs(input int i);
    if (i < 7) return rd[i];
    if (i == 7) return {1'b0, lines_q};
    if (i == 8) return {2'b0, alarm_out_a, alarm_out_b, alarm_out_c, main_trip_q,
                        reclose_inhibit_q, trip_b_latched_q};
    return {3'b0, stage_block_q, second_bank_q};
  endfunction
  task automatic note(input int id, input logic [7:0] v, input int d);
    q.push_back('{id, v, cyc + d});
  endtask
  task automatic chk(input int i, input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm[i], want, seen);
    end
  endtask
  always @(negedge core_clk) begin
    while (q.size() > 0 && q[0].due <= cyc) begin
      chk(q[0].id, obs(q[0].id), q[0].v);
      void'(q.pop_front());
    end
  end
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge core_clk);
    sw_we <= 1'b1;
    sw_sel <= s;
    sw_wdata <= d;
    @(posedge core_clk);
    sw_we <= 1'b0;
    if (s != 3'h7) begin
      sh[s] = d;
      note(int'(s), d, 1);
    end
  endtask
  task automatic go(input logic [7:0] s, input logic b, input logic rp, input logic ck);
    logic [12:0] x;
    @(posedge core_clk);
    cmd_start <= s[7:4];
    cmd_op <= s[3:0];
    cmd_block <= b;
    cmd_busy <= rp;
    s[7:4] = s[7:4] | s[3:0];
    x = expv(s, b, rp);
    if (ck) begin
      note(7, {1'b0, x[6:0]}, 3);
      note(8, {2'b0, x[12:7]}, 3);
      note(9, {3'b0, (b ? sh[0][3:0] : 4'h0), b & sh[0][4]}, 3);
    end
    repeat (2) @(posedge core_clk);
  endtask
  task automatic give_verdict();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_count = err_count + 1;
    give_verdict();
  end
  initial begin
    int i;
    logic [31:0] v;
    logic [31:0] w;
    logic [7:0] m1;
    logic [7:0] m3;
    rst_n = 1'b0;
    {cmd_start, cmd_op, cmd_block, cmd_busy, alarm_delay_en, sw_we, sw_sel, sw_wdata} = 0;
    {cyc, err_count, samples_checked} = 0;
    sh = '{8'h00, 8'hab, 8'ha5, 8'h00, 8'h00, 8'h00, 8'h07};
    v = $urandom(32'h1665dce1);
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (i = 0; i < 7; i++) note(i, sh[i], 1);
    go(8'h01, 1'b0, 1'b0, 1'b1);
    for (i = 0; i < 60; i++) begin
      v = $urandom;
      w = $urandom;
      m1 = v[15:8];
      m3 = v[23:16];
      // Earth-low trips stay off the matrix while that stage only signals.
      if (!v[2]) begin
        m1[5] = 1'b0;
        m3[5:4] = 2'b00;
      end
      wr(3'h0, {3'b0, v[28:24]});
      wr(3'h1, m1);
      wr(3'h2, w[7:0]);
      wr(3'h3, m3);
      wr(3'h5, w[15:8] & 8'hc0);
      wr(3'h6, v[7:0] & 8'hc7);
      go(w[23:16], w[24], w[25], 1'b1);
    end
    wr(3'h1, 8'hab);
    wr(3'h2, 8'ha5);
    wr(3'h3, 8'h00);
    wr(3'h5, 8'h00);
    wr(3'h6, 8'h06);
    for (i = 0; i < 2; i++) begin
      wr(3'h0, i ? 8'h40 : 8'h20);
      go(i ? 8'h08 : 8'h01, 1'b0, 1'b0, 1'b0);
      go(8'h00, 1'b0, 1'b0, 1'b0);
      note(7, 8'h20, 1);
      note(8, 8'h25, 1);
      wr(3'h0, i ? 8'hc0 : 8'ha0);
      // The latch clears on the edge that first sees the remote reset, so the
      // outputs are clean one call later.
      go(8'h00, 1'b1, 1'b0, 1'b0);
      go(8'h00, 1'b1, 1'b0, 1'b1);
      go(8'h00, 1'b0, 1'b0, 1'b1);
    end
    wr(3'h0, 8'h00);
    alarm_delay_en <= 1'b1;
    go(8'h01, 1'b0, 1'b0, 1'b0);
    note(8, 8'h0c, 8);
    note(8, 8'h2c, AD + 6);
    repeat (AD + 8) @(posedge core_clk);
    go(8'h00, 1'b0, 1'b0, 1'b0);
    alarm_delay_en <= 1'b0;
    wr(3'h4, 8'h08);
    go(8'h01, 1'b0, 1'b0, 1'b0);
    note(7, 8'h3a, 8);
    note(7, 8'h7a, BK + 6);
    repeat (BK + 8) @(posedge core_clk);
    go(8'h00, 1'b0, 1'b0, 1'b0);
    wr(3'h4, 8'h00);
    wr(3'h7, 8'hff);
    for (i = 0; i < 7; i++) note(i, sh[i], 1);
    repeat (6) @(posedge core_clk);
    give_verdict();
  end
endmodule
`default_nettype wire
